//--- common/air_pkg.sv
/*
 * air_pkg: register indices, field positions, reset values and widths for
 * the converter event flag and result register bank.
 * Assumes a 32-bit APB with one register per aligned word, byte address =
 * four times the register index.
 */
`default_nettype none

package air_pkg;

	localparam int AIR_ADDR_W = 12;
	localparam int AIR_NSRC   = 5;

	// register indices; byte address is index times four
	localparam logic [7:0] AIR_IDX_FLAGS   = 8'hE7;
	localparam logic [7:0] AIR_IDX_ENABLES = 8'hE8;
	localparam logic [7:0] AIR_IDX_THR_LO  = 8'hE9;
	localparam logic [7:0] AIR_IDX_THR_HI  = 8'hEA;
	localparam logic [7:0] AIR_IDX_VI_LO   = 8'hF1;
	localparam logic [7:0] AIR_IDX_VI_HI   = 8'hF2;
	localparam logic [7:0] AIR_IDX_VA_B0   = 8'hF3;
	localparam logic [7:0] AIR_IDX_VA_B1   = 8'hF4;
	localparam logic [7:0] AIR_IDX_VA_B2   = 8'hF5;
	localparam logic [7:0] AIR_IDX_VA_B3   = 8'hF6;
	localparam logic [7:0] AIR_IDX_CMP_CTL = 8'hF8;
	localparam logic [7:0] AIR_IDX_STATUS  = 8'hF9;

	// event sources in source order: 0 curr inst, 1 curr acc, 2 regular
	// current, 3 volt inst, 4 volt acc; bit positions in the flag byte
	localparam int AIR_POS_CURR_INST = 0;
	localparam int AIR_POS_CURR_ACC  = 1;
	localparam int AIR_POS_REG_CURR  = 2;
	localparam int AIR_POS_VOLT_INST = 4;
	localparam int AIR_POS_VOLT_ACC  = 5;
	localparam logic [7:0] AIR_FLAG_MASK = 8'h37;

	// threshold bit 15 reads zero
	localparam logic [7:0] AIR_THR_HI_MASK = 8'h7F;

	// accumulated voltage result: 17 bits at 31:15
	localparam int AIR_VA_W   = 17;
	localparam int AIR_VA_LSB = 15;

	// comparator control: mode at 5:4, count limit at 3:0
	localparam int AIR_CMP_MODE_LSB = 4;
	localparam logic [1:0] AIR_MODE_RESET = 2'h1;
	localparam logic [1:0] AIR_MODE_UPDN  = 2'h2;

	// status: inst read busy at 0, acc read busy at 1
	localparam int AIR_ST_INST_BUSY = 0;
	localparam int AIR_ST_ACC_BUSY  = 1;

	localparam logic [7:0]  AIR_RST_BYTE = 8'h00;
	localparam logic [31:0] AIR_RST_WORD = 32'h0000_0000;

endpackage

`default_nettype wire

//--- verilog/air_regs.sv
/*
 * air_regs: event flags and enables, regular current threshold and
 * comparator, voltage converter result registers with read freeze, on an
 * APB slave with zero wait states.
 * Assumes converter strobes, result data and the vector logic run on the
 * same clock, each done strobe lasting one cycle, so no synchroniser is
 * placed on them; a strobe from another clock needs one outside this block.
 */
// Implementation choice: the APB interface to the registers.
`default_nettype none

// Behaviour
// - volt accumulated update sets flag bit 5
// - volt instantaneous update sets flag bit 4
// - regular current condition sets flag bit 2
// - current accumulated done sets flag bit 1
// - current instantaneous done sets flag bit 0
// - vector acknowledge clears its flag
// - writing one clears flag, zero keeps
// - request needs flag, enable and global enable
// - enables sit at their flag positions
// - bits 7, 6, 3 reserved, read zero
// - 16-bit threshold, bit 15 reads zero
// - threshold judges accumulated current samples
// - volt instantaneous result in two bytes
// - low byte read freezes until high read
// - instantaneous busy flag high during read
// - accumulated result at 31:15, rest zero
// - lower byte read freezes until top read
// - accumulated busy flag high during read
// - mode 01 resets, 10 counts down
// - condition when count reaches limit plus one
module air_regs
	import air_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [AIR_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	input  wire logic                  curr_inst_done,
	input  wire logic                  curr_acc_done,
	input  wire logic signed [17:0]    curr_acc_value,
	input  wire logic                  volt_inst_done,
	input  wire logic [15:0]           volt_inst_value,
	input  wire logic                  volt_acc_done,
	input  wire logic [16:0]           volt_acc_value,
	input  wire logic                  global_irq_enable,
	input  wire logic [AIR_NSRC-1:0]   irq_ack,
	output logic [AIR_NSRC-1:0]        irq_req,
	output logic                       volt_inst_read_busy,
	output logic                       volt_acc_read_busy
);

	// one register per aligned word; low address bits must be zero
	function automatic logic hit(input logic [AIR_ADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a == {2'b00, idx, 2'b00});
	endfunction

	localparam int SRC_POS [AIR_NSRC] = '{AIR_POS_CURR_INST, AIR_POS_CURR_ACC,
		AIR_POS_REG_CURR, AIR_POS_VOLT_INST, AIR_POS_VOLT_ACC};

	logic [AIR_NSRC-1:0]    flag_r;
	logic [AIR_NSRC-1:0]    enable_r;
	logic [14:0]            thr_r;
	logic [5:0]             cmp_ctl_r;
	logic [15:0]            vi_r;
	logic [AIR_VA_W-1:0]    va_r;
	logic                   vi_lock_r;
	logic                   va_lock_r;
	logic [4:0]             rc_cnt_r;
	logic [4:0]             rc_cnt_nxt;
	logic                   pready_r;
	logic                   pslverr_r;
	logic [31:0]            prdata_r;
	logic [AIR_NSRC-1:0]    irq_r;

	// bus phases: reads act at setup, writes at the completing access edge
	wire setup_rd  = psel & ~penable & ~pwrite;
	wire access_wr = psel & penable & pwrite & pready_r & pstrb[0];

	wire sel_flags = hit(paddr, AIR_IDX_FLAGS);
	wire sel_en    = hit(paddr, AIR_IDX_ENABLES);
	wire sel_thl   = hit(paddr, AIR_IDX_THR_LO);
	wire sel_thh   = hit(paddr, AIR_IDX_THR_HI);
	wire sel_vil   = hit(paddr, AIR_IDX_VI_LO);
	wire sel_vih   = hit(paddr, AIR_IDX_VI_HI);
	wire sel_va0   = hit(paddr, AIR_IDX_VA_B0);
	wire sel_va1   = hit(paddr, AIR_IDX_VA_B1);
	wire sel_va2   = hit(paddr, AIR_IDX_VA_B2);
	wire sel_va3   = hit(paddr, AIR_IDX_VA_B3);
	wire sel_cmp   = hit(paddr, AIR_IDX_CMP_CTL);
	wire sel_st    = hit(paddr, AIR_IDX_STATUS);
	wire mapped    = sel_flags | sel_en | sel_thl | sel_thh | sel_vil | sel_vih
		| sel_va0 | sel_va1 | sel_va2 | sel_va3 | sel_cmp | sel_st;

	wire [7:0] wbyte = pwdata[7:0];

	// spread source-ordered bits onto their byte positions
	logic [7:0] flag_byte;
	logic [7:0] en_byte;
	logic [AIR_NSRC-1:0] w1c;
	genvar gi;
	generate
		for (gi = 0; gi < AIR_NSRC; gi++) begin : g_src
			assign flag_byte[SRC_POS[gi]] = flag_r[gi];
			assign en_byte[SRC_POS[gi]]   = enable_r[gi];
			assign w1c[gi] = access_wr & sel_flags & wbyte[SRC_POS[gi]];
		end
	endgenerate
	assign flag_byte[7:6] = 2'b00;
	assign flag_byte[3]   = 1'b0;
	assign en_byte[7:6]   = 2'b00;
	assign en_byte[3]     = 1'b0;

	// freeze: lock taken at the setup of a lower-byte read, freed by the top;
	// the taking edge already blocks the update, or the bytes would mismatch
	wire vi_lock_take = setup_rd & sel_vil;
	wire vi_lock_free = setup_rd & sel_vih;
	wire va_lock_take = setup_rd & (sel_va0 | sel_va1 | sel_va2);
	wire va_lock_free = setup_rd & sel_va3;
	wire vi_update    = volt_inst_done & ~vi_lock_r & ~vi_lock_take;
	wire va_update    = volt_acc_done & ~va_lock_r & ~va_lock_take;

	// comparator: accumulated current against the unsigned threshold
	wire [1:0] rc_mode  = cmp_ctl_r[AIR_CMP_MODE_LSB +: 2];
	wire [4:0] rc_limit = {1'b0, cmp_ctl_r[3:0]} + 5'h01;
	wire rc_above = curr_acc_value > $signed({3'b000, thr_r});
	wire rc_on    = (rc_mode == AIR_MODE_RESET) | (rc_mode == AIR_MODE_UPDN);
	wire rc_hit   = curr_acc_done & rc_on & rc_above & ((rc_cnt_r + 5'h01) == rc_limit);

	// disabled or reserved mode holds the counter at zero
	always_comb begin
		rc_cnt_nxt = rc_cnt_r;
		if (!rc_on) begin
			rc_cnt_nxt = 5'h00;
		end else if (curr_acc_done) begin
			if (rc_hit) begin
				rc_cnt_nxt = 5'h00;
			end else if (rc_above) begin
				rc_cnt_nxt = rc_cnt_r + 5'h01;
			end else if (rc_mode == AIR_MODE_RESET) begin
				rc_cnt_nxt = 5'h00;
			end else if (rc_cnt_r != 5'h00) begin
				rc_cnt_nxt = rc_cnt_r - 5'h01;
			end
		end
	end

	wire [AIR_NSRC-1:0] set_ev = {va_update, vi_update, rc_hit, curr_acc_done,
		curr_inst_done};

	// set beats both clears so an event is never lost
	wire [AIR_NSRC-1:0] flag_nxt;
	generate
		for (gi = 0; gi < AIR_NSRC; gi++) begin : g_flag
			assign flag_nxt[gi] = set_ev[gi] | (flag_r[gi] & ~w1c[gi] & ~irq_ack[gi]);
		end
	endgenerate

	wire [31:0] va_word = {va_r, {AIR_VA_LSB{1'b0}}};

	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = AIR_RST_BYTE;
		if (sel_flags)
			rd_byte = flag_byte;
		else if (sel_en)
			rd_byte = en_byte;
		else if (sel_thl)
			rd_byte = thr_r[7:0];
		else if (sel_thh)
			rd_byte = {1'b0, thr_r[14:8]};
		else if (sel_vil)
			rd_byte = vi_r[7:0];
		else if (sel_vih)
			rd_byte = vi_r[15:8];
		else if (sel_va0)
			rd_byte = va_word[7:0];
		else if (sel_va1)
			rd_byte = va_word[15:8];
		else if (sel_va2)
			rd_byte = va_word[23:16];
		else if (sel_va3)
			rd_byte = va_word[31:24];
		else if (sel_cmp)
			rd_byte = {2'b00, cmp_ctl_r};
		else if (sel_st)
			rd_byte = {6'h00, va_lock_r, vi_lock_r};
	end

	// write strobes and next values; the flops below only copy them
	wire wr_en  = access_wr & sel_en;
	wire wr_thl = access_wr & sel_thl;
	wire wr_thh = access_wr & sel_thh;
	wire wr_cmp = access_wr & sel_cmp;

	wire [AIR_NSRC-1:0] en_wdata    = {wbyte[AIR_POS_VOLT_ACC], wbyte[AIR_POS_VOLT_INST],
		wbyte[AIR_POS_REG_CURR], wbyte[AIR_POS_CURR_ACC], wbyte[AIR_POS_CURR_INST]};
	wire [AIR_NSRC-1:0] enable_nxt  = wr_en ? en_wdata : enable_r;
	wire [7:0]          thr_lo_nxt  = wr_thl ? wbyte : thr_r[7:0];
	wire [6:0]          thr_hi_nxt  = wr_thh ? wbyte[6:0] : thr_r[14:8];
	wire [5:0]          cmp_ctl_nxt = wr_cmp ? wbyte[5:0] : cmp_ctl_r;
	wire [15:0]         vi_nxt      = vi_update ? volt_inst_value : vi_r;
	wire [AIR_VA_W-1:0] va_nxt      = va_update ? volt_acc_value : va_r;
	wire                vi_lock_nxt = vi_lock_take | (vi_lock_r & ~vi_lock_free);
	wire                va_lock_nxt = va_lock_take | (va_lock_r & ~va_lock_free);

	// APB answer: pready in the first access cycle, no wait states
	wire                pready_nxt  = psel & ~penable;
	wire                pslverr_nxt = psel & ~penable & ~mapped;
	wire [31:0]         prdata_nxt  = setup_rd ? {24'h00_0000, rd_byte} : AIR_RST_WORD;

	// request follows the next flag value, so request and flag show together
	wire [AIR_NSRC-1:0] irq_gate    = enable_r & {AIR_NSRC{global_irq_enable}};
	wire [AIR_NSRC-1:0] irq_nxt     = flag_nxt & irq_gate;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pready_r <= 1'h0;
		end else begin
			pready_r <= pready_nxt;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pslverr_r <= 1'h0;
		end else begin
			pslverr_r <= pslverr_nxt;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prdata_r <= AIR_RST_WORD;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	// flags: a set and a clear on one edge keep the flag
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			flag_r <= 5'h00;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			enable_r <= 5'h00;
		end else begin
			enable_r <= enable_nxt;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			thr_r <= 15'h0000;
		end else begin
			thr_r <= {thr_hi_nxt, thr_lo_nxt};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cmp_ctl_r <= 6'h00;
		end else begin
			cmp_ctl_r <= cmp_ctl_nxt;
		end
	end

	// counter restarts after each condition
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rc_cnt_r <= 5'h00;
		end else begin
			rc_cnt_r <= rc_cnt_nxt;
		end
	end

	// results take no bus writes, only converter data
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			vi_r <= 16'h0000;
		end else begin
			vi_r <= vi_nxt;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			va_r <= 17'h00000;
		end else begin
			va_r <= va_nxt;
		end
	end

	// a top read with no lower read before it leaves the lock clear
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			vi_lock_r <= 1'h0;
		end else begin
			vi_lock_r <= vi_lock_nxt;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			va_lock_r <= 1'h0;
		end else begin
			va_lock_r <= va_lock_nxt;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_r <= 5'h00;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	assign pready              = pready_r;
	assign pslverr             = pslverr_r;
	assign prdata              = prdata_r;
	assign irq_req             = irq_r;
	assign volt_inst_read_busy = vi_lock_r;
	assign volt_acc_read_busy  = va_lock_r;

endmodule

`default_nettype wire

//--- verification/air_regs_monitor.sv
/* air_regs_monitor: port-level checks of the flag and result register bank.
 * Assumes one clock domain and the air_pkg register indices. */
`default_nettype none
module air_regs_monitor
	import air_pkg::*;
(
	input wire logic                  clock,
	input wire logic                  reset_n,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [AIR_ADDR_W-1:0] paddr,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  curr_inst_done,
	input wire logic                  global_irq_enable,
	input wire logic [AIR_NSRC-1:0]   irq_ack,
	input wire logic [AIR_NSRC-1:0]   irq_req,
	input wire logic                  volt_inst_read_busy,
	input wire logic                  volt_acc_read_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// read side effects land at the setup edge
	sequence s_rd(logic [7:0] i);
		psel && !penable && !pwrite && paddr == {2'h0, i, 2'h0};
	endsequence
	sequence s_rdy(logic [7:0] i);
		pready && !pwrite && paddr == {2'h0, i, 2'h0};
	endsequence
	a_vi_lock: assert property (s_rd(AIR_IDX_VI_LO) |=> volt_inst_read_busy)
		else $error("inst busy missing");
	a_vi_unlock: assert property (s_rd(AIR_IDX_VI_HI) |=> !volt_inst_read_busy)
		else $error("inst busy stuck");
	a_va_lock: assert property (s_rd(AIR_IDX_VA_B0) |=> volt_acc_read_busy)
		else $error("acc busy missing");
	a_va_unlock: assert property (s_rd(AIR_IDX_VA_B3) |=> !volt_acc_read_busy)
		else $error("acc busy stuck");
	a_req_global: assert property (!global_irq_enable [*2] |-> irq_req == 5'h00)
		else $error("request without global enable");
	a_ack_clear: assert property (irq_ack[0] && !curr_inst_done |-> ##[1:2] !irq_req[0])
		else $error("ack left request");
	a_thr_top: assert property (s_rdy(AIR_IDX_THR_HI) |-> prdata[31:7] == 25'h0000000)
		else $error("threshold top bit set");
	a_rsv_bits: assert property ((s_rdy(AIR_IDX_FLAGS) or s_rdy(AIR_IDX_ENABLES))
		|-> (prdata & 32'hFFFF_FFC8) == 32'h0000_0000) else $error("reserved bit set");
	a_va_low: assert property (s_rdy(AIR_IDX_VA_B0) |-> prdata == 32'h0000_0000)
		else $error("acc low byte not zero");
endmodule
bind air_regs air_regs_monitor air_regs_monitor_i (.clock, .reset_n, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .curr_inst_done, .global_irq_enable, .irq_ack,
	.irq_req, .volt_inst_read_busy, .volt_acc_read_busy);
`default_nettype wire

//--- verification/air_core_model.sv
/* air_core_model: core vector logic, acks the lowest pending request.
 * Assumes irq_req levels on the same clock; slow adds a delay. */
`default_nettype none
module air_core_model (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       serve,
	input  wire logic       slow,
	input  wire logic [4:0] irq_req,
	output logic      [4:0] irq_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] wait_r;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_ack <= 5'h00;
			wait_r  <= 3'h0;
		end else if (irq_ack != 5'h00)
			irq_ack <= 5'h00;
		else if (serve && irq_req != 5'h00 && wait_r >= {slow, 2'h0}) begin
			irq_ack <= irq_req & -irq_req;
			wait_r  <= 3'h0;
		end else if (irq_req != 5'h00)
			wait_r <= wait_r + 3'h1;
	end
endmodule
`default_nettype wire

//--- verification/air_regs_tb.sv
/* air_regs_tb: directed checks of the event flag and result register bank.
 * Assumes zero-wait APB slave and air_core_model as vector logic. */
`default_nettype none
module air_regs_tb
	import air_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic curr_inst_done = 1'b0, curr_acc_done = 1'b0, volt_inst_done = 1'b0;
	logic volt_acc_done = 1'b0, global_irq_enable = 1'b1, serve = 1'b0, slow = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [3:0] pstrb = 4'hF;
	logic signed [17:0] curr_acc_value = 18'h00000;
	logic [15:0] volt_inst_value = 16'h0000;
	logic [16:0] volt_acc_value = 17'h00000;
	logic [4:0] irq_ack, irq_req;
	logic pready, pslverr, volt_inst_read_busy, volt_acc_read_busy, slv;
	logic [7:0] q;
	int err_total = 0, comparisons = 0, cyc = 0;
	air_regs air_regs_i (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.pready, .prdata, .pslverr, .curr_inst_done, .curr_acc_done, .curr_acc_value,
		.volt_inst_done, .volt_inst_value, .volt_acc_done, .volt_acc_value,
		.global_irq_enable, .irq_ack, .irq_req, .volt_inst_read_busy, .volt_acc_read_busy);
	air_core_model air_core_model_i (.clock, .reset_n, .serve, .slow, .irq_req, .irq_ack);
	always #4 clock = ~clock;
	// hang guard, well above the few hundred cycles the run needs
	always @(posedge clock) begin
		cyc++;
		if (cyc > 3000) begin
			err_total++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= {24'h000000, d};
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata[7:0];
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		apb(1'b0, i, 8'h00);
		cmp("read", {24'h000000, e}, {24'h000000, q});
	endtask
	task automatic ev(input logic [3:0] k);
		{volt_acc_done, volt_inst_done, curr_acc_done, curr_inst_done} <= k;
		@(posedge clock);
		{volt_acc_done, volt_inst_done, curr_acc_done, curr_inst_done} <= 4'h0;
		@(posedge clock);
	endtask
	task automatic t_regs();
		logic [7:0] ids[10] = '{8'hE7, 8'hE8, 8'hE9, 8'hEA, 8'hF1, 8'hF2, 8'hF3, 8'hF4,
			8'hF5, 8'hF6};
		foreach (ids[k]) rd(ids[k], 8'h00);
		apb(1'b0, 8'h00, 8'h00);
		cmp("unmapped", 32'h1, {31'h0, slv});
		apb(1'b1, AIR_IDX_ENABLES, 8'hFF);
		rd(AIR_IDX_ENABLES, 8'h37);
		pstrb <= 4'h0;
		apb(1'b1, AIR_IDX_ENABLES, 8'h00);
		pstrb <= 4'hF;
		rd(AIR_IDX_ENABLES, 8'h37);
		apb(1'b1, AIR_IDX_THR_HI, 8'hFF);
		rd(AIR_IDX_THR_HI, 8'h7F);
		apb(1'b1, AIR_IDX_THR_LO, 8'hA5);
		rd(AIR_IDX_THR_LO, 8'hA5);
	endtask
	task automatic t_vinst();
		volt_inst_value <= 16'hBEEF;
		ev(4'h4);
		rd(AIR_IDX_FLAGS, 8'h10);
		cmp("irq_req", 32'h8, {27'h0, irq_req});
		apb(1'b1, AIR_IDX_ENABLES, 8'h27);
		rd(AIR_IDX_ENABLES, 8'h27);
		cmp("irq_req", 32'h0, {27'h0, irq_req});
		apb(1'b1, AIR_IDX_ENABLES, 8'h37);
		global_irq_enable <= 1'b0;
		repeat (3) @(posedge clock);
		cmp("irq_req", 32'h0, {27'h0, irq_req});
		global_irq_enable <= 1'b1;
		apb(1'b1, AIR_IDX_FLAGS, 8'hEF);
		rd(AIR_IDX_FLAGS, 8'h10);
		apb(1'b1, AIR_IDX_FLAGS, 8'h10);
		rd(AIR_IDX_FLAGS, 8'h00);
		rd(AIR_IDX_VI_LO, 8'hEF);
		cmp("inst busy", 32'h1, {31'h0, volt_inst_read_busy});
		volt_inst_value <= 16'h1234;
		ev(4'h4);
		rd(AIR_IDX_VI_HI, 8'hBE);
		cmp("inst busy", 32'h0, {31'h0, volt_inst_read_busy});
		ev(4'h4);
		rd(AIR_IDX_VI_LO, 8'h34);
		rd(AIR_IDX_VI_HI, 8'h12);
	endtask
	task automatic t_vacc();
		logic [31:0] w;
		w = {17'h1ABCD, 15'h0000};
		apb(1'b1, AIR_IDX_FLAGS, 8'hFF);
		volt_acc_value <= 17'h1ABCD;
		ev(4'h8);
		rd(AIR_IDX_FLAGS, 8'h20);
		rd(AIR_IDX_VA_B0, w[7:0]);
		cmp("acc busy", 32'h1, {31'h0, volt_acc_read_busy});
		volt_acc_value <= 17'h00001;
		ev(4'h8);
		rd(AIR_IDX_VA_B1, w[15:8]);
		rd(AIR_IDX_VA_B2, w[23:16]);
		rd(AIR_IDX_VA_B3, w[31:24]);
		cmp("acc busy", 32'h0, {31'h0, volt_acc_read_busy});
	endtask
	task automatic t_curr();
		apb(1'b1, AIR_IDX_FLAGS, 8'hFF);
		apb(1'b1, AIR_IDX_THR_HI, 8'h00);
		apb(1'b1, AIR_IDX_THR_LO, 8'h10);
		apb(1'b1, AIR_IDX_CMP_CTL, 8'h11);
		curr_acc_value <= 18'sh00020;
		ev(4'h2);
		curr_acc_value <= 18'sh00000;
		ev(4'h2);
		curr_acc_value <= 18'sh00020;
		ev(4'h2);
		rd(AIR_IDX_FLAGS, 8'h02);
		ev(4'h2);
		rd(AIR_IDX_FLAGS, 8'h06);
		ev(4'h1);
		rd(AIR_IDX_FLAGS, 8'h07);
		slow <= 1'b1;
		serve <= 1'b1;
		repeat (40) @(posedge clock);
		rd(AIR_IDX_FLAGS, 8'h00);
		serve <= 1'b0;
		apb(1'b1, AIR_IDX_CMP_CTL, 8'h22);
		curr_acc_value <= 18'sh00020;
		ev(4'h2);
		ev(4'h2);
		curr_acc_value <= 18'sh00000;
		ev(4'h2);
		rd(AIR_IDX_FLAGS, 8'h02);
		curr_acc_value <= 18'sh00020;
		ev(4'h2);
		ev(4'h2);
		rd(AIR_IDX_FLAGS, 8'h06);
	endtask
	initial begin
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		t_regs();
		t_vinst();
		t_vacc();
		t_curr();
		print_verdict();
	end
endmodule
`default_nettype wire
